//--- core/standby_buffer_cmd.v
// Command engine for standby, standby immediate and write buffer.
// Assumes a register port master, a spindle controller and a 200 MHz
// clock with synchronous active-low reset.
//
// Function
// - Standby enters standby, loads power-down timeout
// - Standby spins down, interface stays; skip if stopped
// - Commands accepted in standby; write buffer waits for spin-up
// - Power-down countdown runs only in idle
// - Decode 0 off, 1-240 x5s, 241-251 x30min
// - 252 21min, 253 8h, 255 21m15s, 254 aborts
// - Expiry enters standby; host access restarts interval
// - Extended power conditions select deepest standby
// - Standby immediate enters standby, keeps timeout
// - Standby immediate spins down, skip if stopped
// - Write buffer stores one sector of words
// - Buffer write and read share one 512-byte region
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "standby_cmd_defs.vh"
module standby_buffer_cmd #(
    parameter [29:0] UNIT_CYCLES = `UNIT_CYCLES
) (
    input wire ref_clk,
    input wire rstn,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata_reg,
    output reg irq_reg,
    input wire spindle_at_speed,
    output reg spindle_run_reg,
    output reg [1:0] power_state_reg,
    input wire buf_rd_en,
    input wire [7:0] buf_rd_addr,
    output wire [15:0] buf_rd_data
);
    // ****************************************************************
    // States
    // ****************************************************************
    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_DECODE = 2'h1;
    localparam [1:0] S_SPINUP = 2'h2;
    localparam [1:0] S_XFER = 2'h3;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [7:0] opcode_reg;
    reg [7:0] opcode_next;
    reg [7:0] count_reg;
    reg epc_reg;
    reg [2:0] int_mask_reg;
    reg [2:0] int_stat_reg;
    reg [2:0] int_stat_next;
    reg busy_reg;
    reg busy_next;
    reg drq_reg;
    reg drq_next;
    reg err_reg;
    reg err_next;
    reg abt_reg;
    reg abt_next;
    reg [8:0] ptr_reg;
    reg [8:0] ptr_next;
    reg spindle_run_next;
    reg [1:0] power_state_next;
    reg timer_load;
    reg [12:0] timer_units;
    reg done_evt;
    reg abort_evt;
    reg [15:0] rdata_next;
    wire cmd_wr;
    wire data_wr;
    wire host_access;
    wire buf_wr;
    wire timer_run;
    wire timer_expire;
    wire [7:0] status_val;
    wire [7:0] error_val;
    wire [1:0] standby_kind;
    wire [2:0] int_clear;

    // ****************************************************************
    // Register port decode
    // ****************************************************************
    assign cmd_wr = reg_wr && reg_addr == `OFS_COMMAND;
    assign data_wr = reg_wr && reg_addr == `OFS_DATA;
    // Command or data traffic counts as drive access
    assign host_access = cmd_wr || data_wr;
    assign buf_wr = data_wr && drq_reg && state_reg == S_XFER;
    assign int_clear = (reg_wr && reg_addr == `OFS_INT_STAT) ?
        reg_wdata[2:0] : 3'h0;
    // Deepest standby when extended power conditions are on
    assign standby_kind = epc_reg ? `PWR_STANDBY_Z : `PWR_STANDBY;
    // Timer counts only in idle with the spindle up
    assign timer_run = power_state_reg == `PWR_IDLE &&
        spindle_at_speed;

    // Status and error images built from live state
    assign status_val = {~busy_reg ? 1'b0 : 1'b1, ~busy_reg, 1'b0,
        spindle_at_speed, drq_reg, 1'b0, 1'b0, err_reg};
    assign error_val = {5'h00, abt_reg, 2'h0};

    // ****************************************************************
    // Timeout code decode
    // ****************************************************************
    // Returns 5-second units; caller rejects the abort code first
    function [12:0] units_of;
        input [7:0] code;
        reg [12:0] wide;
        begin
            wide = {5'h00, code};
            if (code == `TO_OFF) begin
                units_of = 13'h0000;
            end else if (code <= `TO_LIN_MAX) begin
                units_of = wide;
            end else if (code <= `TO_LONG_MAX) begin
                units_of = (wide - `TO_LONG_BASE) * `TO_30M_UNITS;
            end else if (code == `TO_21M) begin
                units_of = `TO_21M_UNITS;
            end else if (code == `TO_8H) begin
                units_of = `TO_8H_UNITS;
            end else begin
                units_of = wide; // 255 is 255 units
            end
        end
    endfunction

    // ****************************************************************
    // Command sequencer
    // ****************************************************************
    // New commands are refused while busy; spin-up holds them off
    always @* begin
        state_next = state_reg;
        opcode_next = opcode_reg;
        busy_next = busy_reg;
        drq_next = drq_reg;
        err_next = err_reg;
        abt_next = abt_reg;
        ptr_next = ptr_reg;
        spindle_run_next = spindle_run_reg;
        power_state_next = power_state_reg;
        timer_load = 1'b0;
        timer_units = units_of(count_reg);
        done_evt = 1'b0;
        abort_evt = 1'b0;
        case (state_reg)
            S_IDLE: begin
                if (cmd_wr && !busy_reg) begin
                    opcode_next = reg_wdata[7:0];
                    busy_next = 1'b1;
                    err_next = 1'b0;
                    abt_next = 1'b0;
                    state_next = S_DECODE;
                end else if (timer_expire) begin
                    // Interval ran out with no access
                    power_state_next = standby_kind;
                    spindle_run_next = 1'b0;
                end
            end
            S_DECODE: begin
                case (opcode_reg)
                    `OP_STANDBY_A, `OP_STANDBY_B: begin
                        if (count_reg == `TO_ABORT) begin
                            abort_evt = 1'b1;
                        end else begin
                            power_state_next = standby_kind;
                            // Already stopped spindle stays stopped
                            spindle_run_next = 1'b0;
                            timer_load = 1'b1;
                            done_evt = 1'b1;
                        end
                    end
                    `OP_STBY_IMM_A, `OP_STBY_IMM_B: begin
                        // No timer load: timeout stays as it was
                        power_state_next = standby_kind;
                        spindle_run_next = 1'b0;
                        done_evt = 1'b1;
                    end
                    `OP_WRITE_BUF: begin
                        spindle_run_next = 1'b1;
                        state_next = S_SPINUP;
                    end
                    default: begin
                        abort_evt = 1'b1;
                    end
                endcase
            end
            S_SPINUP: begin
                // Wait for operating speed before any data
                if (spindle_at_speed) begin
                    power_state_next = `PWR_IDLE;
                    ptr_next = 9'h000;
                    drq_next = 1'b1;
                    state_next = S_XFER;
                end
            end
            S_XFER: begin
                if (buf_wr) begin
                    ptr_next = ptr_reg + 9'h001;
                    if (ptr_reg == `WORDS_PER_SECTOR - 9'h001) begin
                        drq_next = 1'b0;
                        done_evt = 1'b1;
                    end
                end
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
        // Common completion path
        if (done_evt || abort_evt) begin
            busy_next = 1'b0;
            state_next = S_IDLE;
        end
        if (abort_evt) begin
            err_next = 1'b1;
            abt_next = 1'b1;
        end
    end

    // Sequencer and status flops
    always @(posedge ref_clk) begin
        if (!rstn) begin
            state_reg <= S_IDLE;
            opcode_reg <= 8'h00;
            busy_reg <= 1'b0;
            drq_reg <= 1'b0;
            err_reg <= 1'b0;
            abt_reg <= 1'b0;
            ptr_reg <= 9'h000;
            spindle_run_reg <= 1'b1;
            power_state_reg <= `PWR_IDLE;
        end else begin
            state_reg <= state_next;
            opcode_reg <= opcode_next;
            busy_reg <= busy_next;
            drq_reg <= drq_next;
            err_reg <= err_next;
            abt_reg <= abt_next;
            ptr_reg <= ptr_next;
            spindle_run_reg <= spindle_run_next;
            power_state_reg <= power_state_next;
        end
    end

    // ****************************************************************
    // Software registers
    // ****************************************************************
    // Count and control are plain read/write storage
    always @(posedge ref_clk) begin
        if (!rstn) begin
            count_reg <= `RST_COUNT;
            epc_reg <= `RST_CTRL;
            int_mask_reg <= `RST_MASK;
        end else if (reg_wr) begin
            if (reg_addr == `OFS_COUNT) begin
                count_reg <= reg_wdata[7:0];
            end
            if (reg_addr == `OFS_CTRL) begin
                epc_reg <= reg_wdata[`CTRL_EPC];
            end
            if (reg_addr == `OFS_INT_MASK) begin
                int_mask_reg <= reg_wdata[2:0];
            end
        end
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    // Write-one clears; a same-cycle event wins over the clear
    always @* begin
        int_stat_next = int_stat_reg & ~int_clear;
        if (done_evt || abort_evt) begin
            int_stat_next[`INT_DONE] = 1'b1;
        end
        if (abort_evt) begin
            int_stat_next[`INT_ABORT] = 1'b1;
        end
        if (timer_expire && state_reg == S_IDLE && !cmd_wr) begin
            int_stat_next[`INT_AUTO] = 1'b1;
        end
    end

    // Level output from unmasked sticky bits
    always @(posedge ref_clk) begin
        if (!rstn) begin
            int_stat_reg <= 3'h0;
            irq_reg <= 1'b0;
        end else begin
            int_stat_reg <= int_stat_next;
            irq_reg <= |(int_stat_next & int_mask_reg);
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Unmapped offsets read as zero, one cycle after the strobe
    always @* begin
        case (reg_addr)
            `OFS_COUNT: rdata_next = {8'h00, count_reg};
            `OFS_ERROR: rdata_next = {8'h00, error_val};
            `OFS_STATUS: rdata_next = {8'h00, status_val};
            `OFS_COMMAND: rdata_next = {8'h00, opcode_reg};
            `OFS_CTRL: rdata_next = {15'h0000, epc_reg};
            `OFS_INT_STAT: rdata_next = {13'h0000, int_stat_reg};
            `OFS_INT_MASK: rdata_next = {13'h0000, int_mask_reg};
            `OFS_POWER: rdata_next = {14'h0000, power_state_reg};
            default: rdata_next = 16'h0000;
        endcase
    end

    // Read data only in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (!rstn) begin
            reg_rdata_reg <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata_reg <= rdata_next;
        end else begin
            reg_rdata_reg <= 16'h0000;
        end
    end

    // ****************************************************************
    // Sub-blocks
    // ****************************************************************
    // Each write buffer fills words 0..255 of the same region
    sector_buffer_ram u_buf (
        .ref_clk(ref_clk),
        .wr_en(buf_wr),
        .wr_addr(ptr_reg[7:0]),
        .wr_data(reg_wdata),
        .rd_en(buf_rd_en),
        .rd_addr(buf_rd_addr),
        .rd_data_reg(buf_rd_data)
    );

    // Reloaded only by the standby command
    power_down_timer #(
        .UNIT_CYCLES(UNIT_CYCLES)
    ) u_timer (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .load(timer_load),
        .load_units(timer_units),
        .restart(host_access),
        .run(timer_run),
        .expire_reg(timer_expire)
    );
endmodule // standby_buffer_cmd

//--- core/standby_cmd_defs.vh
// Constants for the standby and buffer-write command block.
// Assumes a 200 MHz clock and an 8-bit register address space.
`ifndef STANDBY_CMD_DEFS_VH
`define STANDBY_CMD_DEFS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_DATA 8'h00
`define OFS_COUNT 8'h01
`define OFS_ERROR 8'h02
`define OFS_STATUS 8'h03
`define OFS_COMMAND 8'h04
`define OFS_CTRL 8'h05
`define OFS_INT_STAT 8'h06
`define OFS_INT_MASK 8'h07
`define OFS_POWER 8'h08

// ****************************************************************
// Opcodes
// ****************************************************************
`define OP_STANDBY_A 8'hE2
`define OP_STANDBY_B 8'h96
`define OP_STBY_IMM_A 8'hE0
`define OP_STBY_IMM_B 8'h94
`define OP_WRITE_BUF 8'hE8

// ****************************************************************
// Field positions
// ****************************************************************
`define ST_BSY 7
`define ST_RDY 6
`define ST_DSC 4
`define ST_DRQ 3
`define ST_ERR 0
`define ER_ABT 2
`define CTRL_EPC 0
`define INT_DONE 0
`define INT_AUTO 1
`define INT_ABORT 2

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_COUNT 8'h00
`define RST_CTRL 1'b0
`define RST_MASK 3'h0
`define RST_UNITS 13'h0000

// ****************************************************************
// Power states
// ****************************************************************
`define PWR_IDLE 2'h0
`define PWR_STANDBY 2'h1
`define PWR_STANDBY_Z 2'h2

// ****************************************************************
// Timeout code decode, results in 5-second units
// ****************************************************************
`define TO_OFF 8'h00
`define TO_LIN_MAX 8'hF0
`define TO_LONG_MAX 8'hFB
`define TO_21M 8'hFC
`define TO_8H 8'hFD
`define TO_ABORT 8'hFE
`define TO_LONG_BASE 13'h00F0
`define TO_30M_UNITS 13'h0168
`define TO_21M_UNITS 13'h00FC
`define TO_8H_UNITS 13'h1680

// ****************************************************************
// Timing
// ****************************************************************
`define UNIT_CYCLES 30'd1000000000 // 5 s at 200 MHz
`define WORDS_PER_SECTOR 9'h100

`endif

//--- core/sector_buffer_ram.v
// Sector buffer: 256 words of 16 bits, one write and one read port.
// Assumes a single clock; read data comes from a register.
`timescale 1ns/1ps
module sector_buffer_ram (
    input wire ref_clk,
    input wire wr_en,
    input wire [7:0] wr_addr,
    input wire [15:0] wr_data,
    input wire rd_en,
    input wire [7:0] rd_addr,
    output reg [15:0] rd_data_reg
);
    reg [15:0] mem [0:255];

    // Storage and registered read, no reset on the array
    always @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data_reg <= mem[rd_addr];
        end
    end
endmodule // sector_buffer_ram

//--- core/power_down_timer.v
// Automatic power-down interval counter in 5-second units.
// Assumes one clock; the unit tick is an internal enable pulse.
`timescale 1ns/1ps
`include "standby_cmd_defs.vh"
module power_down_timer #(
    parameter [29:0] UNIT_CYCLES = `UNIT_CYCLES
) (
    input wire ref_clk,
    input wire rstn,
    input wire load,
    input wire [12:0] load_units,
    input wire restart,
    input wire run,
    output reg expire_reg
);
    reg [12:0] units_reg;
    reg [12:0] remain_reg;
    reg [29:0] div_reg;
    wire tick;

    assign tick = (div_reg == UNIT_CYCLES - 30'h00000001);

    // Countdown only while run is high; otherwise held at full interval
    always @(posedge ref_clk) begin
        if (!rstn) begin
            units_reg <= `RST_UNITS;
            remain_reg <= `RST_UNITS;
            div_reg <= 30'h00000000;
            expire_reg <= 1'b0;
        end else begin
            expire_reg <= 1'b0;
            if (load) begin
                units_reg <= load_units;
                remain_reg <= load_units;
                div_reg <= 30'h00000000;
            end else if (restart || !run || units_reg == 13'h0000) begin
                remain_reg <= units_reg;
                div_reg <= 30'h00000000;
            end else if (tick) begin
                div_reg <= 30'h00000000;
                if (remain_reg == 13'h0001) begin
                    expire_reg <= 1'b1;
                    remain_reg <= units_reg;
                end else begin
                    remain_reg <= remain_reg - 13'h0001;
                end
            end else begin
                div_reg <= div_reg + 30'h00000001;
            end
        end
    end
endmodule // power_down_timer

//--- testbench/spindle_model.sv
// Spindle controller model for the standby command block bench.
// Assumes the run request is a registered level from the block.
`timescale 1ns/1ps
module spindle_model #(
    parameter SPIN_CYCLES = 20
) (
    input wire ref_clk,
    input wire rstn,
    input wire run,
    input wire slow,
    output reg at_speed
);
// ****************************************************************
// Spin-up ramp
// ****************************************************************
integer cnt;
// Speed drops at once on spin-down; a slow ramp takes four times longer
always @(posedge ref_clk) begin
    if (!rstn || !run) begin
        cnt <= 0;
        at_speed <= 1'b0;
    end else if (cnt >= (slow ? 4 * SPIN_CYCLES : SPIN_CYCLES)) begin
        at_speed <= 1'b1;
    end else begin
        cnt <= cnt + 1;
    end
end
endmodule // spindle_model

//--- testbench/standby_buffer_cmd_asserts.sv
// Port checker for the standby and buffer-write command block.
// Assumes it is bound to the block top and sees only its ports.
`timescale 1ns/1ps
`include "standby_cmd_defs.vh"
module standby_buffer_cmd_asserts #(
    parameter [29:0] UNIT_CYCLES = `UNIT_CYCLES
) (
    input wire ref_clk,
    input wire rstn,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata_reg,
    input wire irq_reg,
    input wire spindle_at_speed,
    input wire spindle_run_reg,
    input wire [1:0] power_state_reg,
    input wire buf_rd_en,
    input wire [7:0] buf_rd_addr,
    input wire [15:0] buf_rd_data
);
// ****************************************************************
// Port relations
// ****************************************************************
default clocking cb @(posedge ref_clk);
endclocking
default disable iff (!rstn);
// Read data only in the cycle after a read strobe
property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata_reg == 16'h0000;
endproperty
a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside its cycle");
// All register reads are byte wide
property p_upper_zero;
    reg_rdata_reg[15:8] == 8'h00;
endproperty
a_upper_zero: assert property (p_upper_zero)
    else $error("upper read byte not zero");
property p_pwr_read;
    $past(reg_rd) && $past(reg_addr) == `OFS_POWER
        |-> reg_rdata_reg == {14'h0000, $past(power_state_reg)};
endproperty
a_pwr_read: assert property (p_pwr_read)
    else $error("power state read disagrees with port");
// Ready is the inverse of busy; seek-complete follows spindle speed
property p_rdy_bsy;
    $past(reg_rd) && $past(reg_addr) == `OFS_STATUS
        |-> reg_rdata_reg[`ST_RDY] != reg_rdata_reg[`ST_BSY]
        && reg_rdata_reg[`ST_DSC] == $past(spindle_at_speed);
endproperty
a_rdy_bsy: assert property (p_rdy_bsy)
    else $error("status ready or seek bit wrong");
property p_stby_spin;
    $changed(power_state_reg) && power_state_reg != `PWR_IDLE
        |-> !spindle_run_reg;
endproperty
a_stby_spin: assert property (p_stby_spin)
    else $error("standby entered with spindle running");
property p_idle_spin;
    power_state_reg == `PWR_IDLE |-> spindle_run_reg;
endproperty
a_idle_spin: assert property (p_idle_spin)
    else $error("idle with spindle stopped");
// Leaving standby waits for operating speed
property p_wake_speed;
    $past(power_state_reg) != `PWR_IDLE
        && power_state_reg == `PWR_IDLE |-> $past(spindle_at_speed);
endproperty
a_wake_speed: assert property (p_wake_speed)
    else $error("idle before spindle at speed");
property p_state_legal;
    power_state_reg != 2'h3;
endproperty
a_state_legal: assert property (p_state_legal)
    else $error("illegal power state");
// Interrupt only drops after a register write
property p_irq_fall;
    $fell(irq_reg) |-> $past(reg_wr) || $past(reg_wr, 2);
endproperty
a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt dropped without a write");
c_standby: cover property ($rose(power_state_reg == `PWR_STANDBY));
c_deep: cover property (power_state_reg == `PWR_STANDBY_Z);
c_irq: cover property ($rose(irq_reg));
endmodule // standby_buffer_cmd_asserts

//--- testbench/testbench.sv
// Self-checking bench for the standby and buffer-write command block.
// Assumes the checker and spindle model are compiled with it.
`timescale 1ns/1ps
`include "standby_cmd_defs.vh"
bind standby_buffer_cmd standby_buffer_cmd_asserts #(
    .UNIT_CYCLES(UNIT_CYCLES)
) chk_u (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_reg(reg_rdata_reg), .irq_reg(irq_reg),
    .spindle_at_speed(spindle_at_speed), .spindle_run_reg(spindle_run_reg),
    .power_state_reg(power_state_reg), .buf_rd_en(buf_rd_en),
    .buf_rd_addr(buf_rd_addr), .buf_rd_data(buf_rd_data));
module testbench;
// Short unit keeps the long timeouts inside the run
localparam [29:0] UC = 30'd10;
localparam [39:0] CODES = 40'hFF_FC_F1_05_00;
localparam [79:0] UNITS = {16'd255, 16'd252, 16'd360, 16'd5, 16'd0};
reg ref_clk = 1'b0;
reg rstn = 1'b0;
reg [7:0] reg_addr = 8'h00;
reg [15:0] reg_wdata = 16'h0000;
reg reg_wr = 1'b0;
reg reg_rd = 1'b0;
reg buf_rd_en = 1'b0;
reg [7:0] buf_rd_addr = 8'h00;
reg slow = 1'b0;
wire [15:0] reg_rdata_reg;
wire irq_reg;
wire spindle_at_speed;
wire spindle_run_reg;
wire [1:0] power_state_reg;
wire [15:0] buf_rd_data;
wire [15:0] irq_w = {15'h0000, irq_reg};
wire [15:0] pwr_w = {14'h0000, power_state_reg};
integer failures = 0;
integer checks_done = 0;
integer i, j, n;
reg [15:0] v;
always #2.5 ref_clk = ~ref_clk;
standby_buffer_cmd #(.UNIT_CYCLES(UC)) dut_u (.ref_clk(ref_clk),
    .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg),
    .irq_reg(irq_reg), .spindle_at_speed(spindle_at_speed),
    .spindle_run_reg(spindle_run_reg), .power_state_reg(power_state_reg),
    .buf_rd_en(buf_rd_en), .buf_rd_addr(buf_rd_addr),
    .buf_rd_data(buf_rd_data));
spindle_model spin_u (.ref_clk(ref_clk), .rstn(rstn),
    .run(spindle_run_reg), .slow(slow), .at_speed(spindle_at_speed));
// ****************************************************************
// Bus tasks and checks
// ****************************************************************
task chk(input [15:0] seen, input [15:0] exp);
    begin
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    end
endtask
task wr(input [7:0] a, input [15:0] d);
    begin
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    end
endtask
task rd(input [7:0] a);
    begin
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata_reg;
    end
endtask
task rdchk(input [7:0] a, input [15:0] exp);
    begin
        rd(a);
        chk(v, exp);
    end
endtask
// Bounded wait, so a stuck state shows as a mismatch not a hang
task wait_pwr(input [1:0] exp, input integer lim);
    begin
        for (j = 0; j < lim && power_state_reg !== exp; j = j + 1)
            @(posedge ref_clk);
        #1 chk(pwr_w, {14'h0000, exp});
    end
endtask
// Write buffer: poll for data request, then one sector
task sector(input [15:0] base);
    begin
        wr(`OFS_COMMAND, {8'h00, `OP_WRITE_BUF});
        v = 16'h0000;
        for (j = 0; j < 400 && !v[`ST_DRQ]; j = j + 1)
            rd(`OFS_STATUS);
        chk(v & 16'h0008, 16'h0008);
        for (j = 0; j < 256; j = j + 1)
            wr(`OFS_DATA, base + j[15:0]);
    end
endtask
task results;
    begin
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
endtask
// ****************************************************************
// Scenarios
// ****************************************************************
initial begin
    #300000;
    failures = failures + 1;
    results;
end
initial begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (40) @(posedge ref_clk);
    // Reset values, unmapped read
    rdchk(`OFS_COUNT, 16'h0000);
    rdchk(`OFS_CTRL, 16'h0000);
    rdchk(`OFS_INT_MASK, 16'h0000);
    rdchk(`OFS_POWER, 16'h0000);
    rdchk(`OFS_ERROR, 16'h0000);
    rdchk(`OFS_STATUS, 16'h0050);
    rdchk(8'h3C, 16'h0000);
    // Sector transfer, completion interrupt, stray word dropped
    wr(`OFS_INT_MASK, 16'h0007);
    sector(16'hA5C0);
    rdchk(`OFS_STATUS, 16'h0050);
    rdchk(`OFS_INT_STAT, 16'h0001);
    chk(irq_w, 16'h0001);
    wr(`OFS_INT_STAT, 16'h0001);
    rdchk(`OFS_INT_STAT, 16'h0000);
    wr(`OFS_DATA, 16'hDEAD);
    for (i = 0; i < 256; i = i + 1) begin
        @(posedge ref_clk);
        buf_rd_addr <= i[7:0];
        buf_rd_en <= 1'b1;
        @(posedge ref_clk);
        buf_rd_en <= 1'b0;
        #1 chk(buf_rd_data, 16'hA5C0 + i[15:0]);
    end
    // Code 254 aborts; masked event stays silent until unmasked
    wr(`OFS_INT_MASK, 16'h0000);
    wr(`OFS_COUNT, 16'h00FE);
    wr(`OFS_COMMAND, {8'h00, `OP_STANDBY_A});
    rdchk(`OFS_ERROR, 16'h0004);
    rdchk(`OFS_STATUS, 16'h0051);
    rdchk(`OFS_POWER, 16'h0000);
    rdchk(`OFS_INT_STAT, 16'h0005);
    chk(irq_w, 16'h0000);
    wr(`OFS_INT_MASK, 16'h0007);
    repeat (2) @(posedge ref_clk);
    #1 chk(irq_w, 16'h0001);
    wr(`OFS_INT_STAT, 16'h0005);
    repeat (2) @(posedge ref_clk);
    #1 chk(irq_w, 16'h0000);
    // Deep standby, then immediate again with spindle already stopped
    wr(`OFS_CTRL, 16'h0001);
    wr(`OFS_COMMAND, {8'h00, `OP_STBY_IMM_B});
    wait_pwr(`PWR_STANDBY_Z, 20);
    chk({15'h0000, spindle_run_reg}, 16'h0000);
    wr(`OFS_CTRL, 16'h0000);
    wr(`OFS_COMMAND, {8'h00, `OP_STBY_IMM_A});
    wait_pwr(`PWR_STANDBY, 20);
    rdchk(`OFS_ERROR, 16'h0000);
    wr(`OFS_COMMAND, 16'h0077);
    rdchk(`OFS_ERROR, 16'h0004);
    slow <= 1'b1;
    sector(16'h0000);
    slow <= 1'b0;
    rdchk(`OFS_STATUS, 16'h0050);
    // Timeout codes: idle until the interval, then standby on its own; code 0 stays idle
    for (i = 0; i < 5; i = i + 1) begin
        n = UNITS[i*16 +: 16] * UC;
        wr(`OFS_COUNT, {8'h00, CODES[i*8 +: 8]});
        wr(`OFS_COMMAND, {8'h00, i[0] ? `OP_STANDBY_B : `OP_STANDBY_A});
        wait_pwr(`PWR_STANDBY, 20);
        chk({15'h0000, spindle_run_reg}, 16'h0000);
        repeat (100) @(posedge ref_clk);
        sector(16'h0000);
        repeat (n > 0 ? n - 30 : 300) @(posedge ref_clk);
        chk(pwr_w, 16'h0000);
        wait_pwr(n > 0 ? `PWR_STANDBY : `PWR_IDLE, 60);
        rd(`OFS_INT_STAT);
        chk(v & 16'h0002, n > 0 ? 16'h0002 : 16'h0000);
        wr(`OFS_INT_STAT, 16'h0007);
    end
    // Immediate standby keeps the 255 timeout despite a zero count
    wr(`OFS_COUNT, 16'h0000);
    wr(`OFS_COMMAND, {8'h00, `OP_STBY_IMM_A});
    wait_pwr(`PWR_STANDBY, 20);
    sector(16'h0000);
    repeat (2520) @(posedge ref_clk);
    chk(pwr_w, 16'h0000);
    wait_pwr(`PWR_STANDBY, 60);
    results;
end
endmodule // testbench
